// ---- design/ftb_pkg.sv ----
// package for the flag, test and branch execution unit
package ftb_pkg;
    // instruction field values
    localparam logic [5:0] FTB_OP_TEST   = 6'h18;   // 011000
    localparam logic [5:0] FTB_OP_AND_NOT = 6'h19;  // 011001
    localparam logic [5:0] FTB_OP_BRNZ   = 6'h3A;   // 111010
    localparam logic [5:0] FTB_OP_BRZ    = 6'h3B;   // 111011
    // instruction word field positions
    localparam int FTB_OP_HI   = 31;
    localparam int FTB_OP_LO   = 26;
    localparam int FTB_ZUPD_BIT = 25;
    localparam int FTB_CUPD_BIT = 24;
    localparam int FTB_WR_BIT  = 23;
    localparam int FTB_IMM_BIT = 22;
    localparam int FTB_DST_HI  = 17;
    localparam int FTB_DST_LO  = 9;
    localparam int FTB_SRC_HI  = 8;
    localparam int FTB_SRC_LO  = 0;
    localparam int FTB_IMM_W   = 9;
    localparam int FTB_ADDR_W  = 9;
    localparam int FTB_DATA_W  = 32;
    // cycle counts
    localparam logic [3:0] FTB_CYC_ALU   = 4'h4;
    localparam logic [3:0] FTB_CYC_TAKEN = 4'h4;
    localparam logic [3:0] FTB_CYC_FALL  = 4'h8;
    localparam logic [3:0] FTB_CYC_ONE   = 4'h1;
    // states
    typedef enum logic [0:0] {FTB_IDLE, FTB_BUSY} ftb_state_t;
endpackage

// ---- design/ftb_parity.sv ----
// parity tree for a data word
`timescale 1ns/1ps
`default_nettype none
module ftb_parity #(
    parameter int WIDTH = 32                 // word width
) (
    input  wire logic [WIDTH-1:0] data,      // word to test
    output logic                  odd        // high when odd count of ones
);
    // =====================================================================
    // reduction
    // =====================================================================
    initial begin
        if (WIDTH < 1) begin
            $error("ftb_parity: WIDTH must be positive");
        end
    end

    // xor of all bits; kept separate so the tree can be retimed alone
    always_comb begin
        odd = ^data;
    end
endmodule
`default_nettype wire

// ---- design/ftb_unit.sv ----
// execution unit for flag-only and, and-not, and test-and-branch
// Operation
// - field 011000 decodes as flag-only and of destination with source
// - and result updates flags only unless write-back requested
// - source is register contents or 9-bit immediate by immediate bit
// - zero flag set when masked result is zero, if requested
// - carry flag set when result has odd count of ones, if requested
// - field 011001 decodes as flag-only and with inverted source
// - and-not inverts register or immediate source before the and
// - destination left unchanged unless write-back requested
// - flag-only and with write-back behaves as a normal and
// - flag-only and-not with write-back behaves as normal and-not
// - field 111010 branches when tested register is non-zero
// - field 111011 branches when tested register is zero
// - branch target is register contents or 9-bit immediate
// - on branches zero flag set when tested register is zero
// - branches take 4 cycles when taken, 8 when falling through
`timescale 1ns/1ps
`default_nettype none
module ftb_unit #(
    parameter int DATA_W = ftb_pkg::FTB_DATA_W,   // datapath width
    parameter int ADDR_W = ftb_pkg::FTB_ADDR_W    // program address width
) (
    input  wire logic              mclk,          // core clock
    input  wire logic              resetn,        // async reset, active low
    input  wire logic              issue,         // instruction presented
    input  wire logic [31:0]       instr,         // instruction word
    input  wire logic [DATA_W-1:0] dst_val,       // destination register value
    input  wire logic [DATA_W-1:0] src_val,       // source register value
    input  wire logic              zero_in,       // current zero flag
    input  wire logic              carry_in,      // current carry flag
    output logic                   busy,          // instruction in progress
    output logic                   done,          // last cycle pulse
    output logic                   claimed,       // instruction belongs here
    output logic                   zero_flag,     // zero flag after op
    output logic                   carry_flag,    // carry flag after op
    output logic                   flags_we,      // flags updated pulse
    output logic                   wb_we,         // destination write pulse
    output logic [ADDR_W-1:0]      wb_addr,       // destination index
    output logic [DATA_W-1:0]      wb_data,       // destination write data
    output logic                   jump,          // branch taken pulse
    output logic [ADDR_W-1:0]      jump_addr      // branch target
);
    import ftb_pkg::*;

    // =====================================================================
    // elaboration checks
    // =====================================================================
    initial begin
        if (DATA_W < FTB_IMM_W || ADDR_W < 1 || ADDR_W > DATA_W) begin
            $error("ftb_unit: unsupported width parameters");
        end
        // the literal field must be exactly as wide as the immediate
        if (FTB_SRC_HI - FTB_SRC_LO + 1 != FTB_IMM_W) begin
            $error("ftb_unit: source field and immediate width disagree");
        end
        // a narrow address port would silently drop destination bits
        if (FTB_DST_HI - FTB_DST_LO + 1 > ADDR_W) begin
            $error("ftb_unit: destination field wider than address port");
        end
        // the opcode field must match the width of the decode constants
        if (FTB_OP_HI - FTB_OP_LO + 1 != $bits(FTB_OP_TEST)) begin
            $error("ftb_unit: opcode field width mismatch");
        end
        // effect bits sit between the destination field and the opcode
        if (FTB_IMM_BIT <= FTB_DST_HI || FTB_ZUPD_BIT >= FTB_OP_LO) begin
            $error("ftb_unit: effect bits overlap another field");
        end
        // busy leaves when the count reaches one, so a count of one
        // or less would let the down counter wrap and stretch the instruction to 16 or 17 cycles
        if (FTB_CYC_ALU <= FTB_CYC_ONE || FTB_CYC_TAKEN <= FTB_CYC_ONE ||
            FTB_CYC_FALL <= FTB_CYC_ONE) begin
            $error("ftb_unit: cycle counts too short for the down counter");
        end
    end

    // =====================================================================
    // decode
    // =====================================================================
    // word layout: opcode on top, four effect bits below it, then the
    // destination index and the source index or literal at the bottom
    logic [5:0]        op;
    logic              op_test;
    logic              op_and_not;
    logic              op_brnz;
    logic              op_brz;
    logic              is_ours;
    logic [DATA_W-1:0] src_opnd;
    logic [DATA_W-1:0] masked;
    logic              parity_odd;
    logic              dst_zero;
    logic              take;

    // opcode compare against the four field values
    always_comb begin
        op         = instr[FTB_OP_HI:FTB_OP_LO];
        op_test    = (op == FTB_OP_TEST);
        op_and_not = (op == FTB_OP_AND_NOT);
        op_brnz    = (op == FTB_OP_BRNZ);
        op_brz     = (op == FTB_OP_BRZ);
        is_ours    = op_test | op_and_not | op_brnz | op_brz;
    end

    // source select; immediate is zero-extended, never sign-extended
    // with the immediate bit clear the low field is a register index instead
    always_comb begin
        if (instr[FTB_IMM_BIT]) begin
            src_opnd = {{(DATA_W-FTB_IMM_W){1'b0}},
                        instr[FTB_SRC_HI:FTB_SRC_LO]};
        end else begin
            src_opnd = src_val;
        end
    end

    // masking: invert the source for the and-not form
    // zero test and branch outcome look at the destination alone
    always_comb begin
        if (op_and_not) begin
            masked = dst_val & ~src_opnd;
        end else begin
            masked = dst_val & src_opnd;
        end
        dst_zero = (dst_val == '0);
        take     = op_brnz ? !dst_zero : dst_zero;
    end

    // parity of the masked word, ready in the issue cycle
    ftb_parity #(
        .WIDTH (DATA_W)
    ) u_parity (
        .data (masked),
        .odd  (parity_odd)
    );

    // =====================================================================
    // sequencing and results
    // =====================================================================
    ftb_state_t        state_q,   state_d;
    logic [3:0]        cnt_q,     cnt_d;
    logic              busy_q,    busy_d;
    logic              done_q,    done_d;
    logic              claim_q,   claim_d;
    logic              z_q,       z_d;
    logic              c_q,       c_d;
    logic              fwe_q,     fwe_d;
    logic              wwe_q,     wwe_d;
    logic [ADDR_W-1:0] waddr_q,   waddr_d;
    logic [DATA_W-1:0] wdata_q,   wdata_d;
    logic              jmp_q,     jmp_d;
    logic [ADDR_W-1:0] jaddr_q,   jaddr_d;
    logic              pend_q,    pend_d;
    logic              jtake_q,   jtake_d;

    // results are produced at issue and released on the final cycle, so
    // the core sees all effects together when the instruction retires
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        claim_d = 1'b0;
        z_d     = z_q;
        c_d     = c_q;
        fwe_d   = 1'b0;
        wwe_d   = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        jmp_d   = 1'b0;
        jaddr_d = jaddr_q;
        pend_d  = pend_q;
        unique case (state_q)
            FTB_IDLE: begin
                // only an idle unit takes a word; issue while busy is dropped
                if (issue && is_ours) begin
                    claim_d = 1'b1;
                    busy_d  = 1'b1;
                    state_d = FTB_BUSY;
                    pend_d  = 1'b0;
                    z_d     = zero_in;
                    c_d     = carry_in;
                    waddr_d = ADDR_W'(instr[FTB_DST_HI:FTB_DST_LO]);
                    wdata_d = masked;
                    if (op_test || op_and_not) begin
                        cnt_d = FTB_CYC_ALU - FTB_CYC_ONE;
                        if (instr[FTB_ZUPD_BIT]) begin
                            z_d = (masked == '0);
                        end
                        if (instr[FTB_CUPD_BIT]) begin
                            c_d = parity_odd;
                        end
                        // write-back turns these into plain and / and-not
                        pend_d = instr[FTB_WR_BIT];
                    end else begin
                        if (instr[FTB_ZUPD_BIT]) begin
                            z_d = dst_zero;
                        end
                        // branches report the carry as cleared, never as parity
                        if (instr[FTB_CUPD_BIT]) begin
                            c_d = 1'b0;
                        end
                        wdata_d = dst_val;                     // unchanged value
                        pend_d  = instr[FTB_WR_BIT];
                        jaddr_d = ADDR_W'(src_opnd);
                        cnt_d   = take ? FTB_CYC_TAKEN - FTB_CYC_ONE
                                       : FTB_CYC_FALL - FTB_CYC_ONE;
                    end
                    jmp_d = 1'b0;
                end
            end
            FTB_BUSY: begin
                // the done cycle is already idle, so a new word may be taken there
                if (cnt_q == FTB_CYC_ONE) begin
                    state_d = FTB_IDLE;
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    fwe_d   = 1'b1;
                    wwe_d   = pend_q;
                    jmp_d   = (cnt_q == FTB_CYC_ONE) && jtake_q;
                end
                cnt_d = cnt_q - FTB_CYC_ONE;
            end
        endcase
    end

    // =====================================================================
    // branch outcome
    // =====================================================================
    // the outcome is fixed at issue; the register may change while busy,
    // so the jump must not look at the live operand again
    always_comb begin
        jtake_d = jtake_q;
        if (state_q == FTB_IDLE && issue && is_ours) begin
            jtake_d = (op_brnz || op_brz) && take;
        end
    end

    // outcome register, kept apart from the sequencer group
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            jtake_q <= 1'b0;
        end else begin
            jtake_q <= jtake_d;
        end
    end

    // =====================================================================
    // sequencer and result registers
    // =====================================================================
    // state registers; reset leaves every pulse low so nothing fires early
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= FTB_IDLE;
            cnt_q   <= '0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            claim_q <= 1'b0;
            z_q     <= 1'b0;
            c_q     <= 1'b0;
            fwe_q   <= 1'b0;
            wwe_q   <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            jmp_q   <= 1'b0;
            jaddr_q <= '0;
            pend_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            claim_q <= claim_d;
            z_q     <= z_d;
            c_q     <= c_d;
            fwe_q   <= fwe_d;
            wwe_q   <= wwe_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            jmp_q   <= jmp_d;
            jaddr_q <= jaddr_d;
            pend_q  <= pend_d;
        end
    end

    // =====================================================================
    // output stage
    // =====================================================================
    // outputs straight from flip-flops
    // no logic after the registers, so the core sees clean timing
    always_comb begin
        busy       = busy_q;
        done       = done_q;
        claimed    = claim_q;
        zero_flag  = z_q;
        carry_flag = c_q;
        flags_we   = fwe_q;
        wb_we      = wwe_q;
        wb_addr    = waddr_q;
        wb_data    = wdata_q;
        jump       = jmp_q;
        jump_addr  = jaddr_q;
    end
endmodule
`default_nettype wire

// ---- verif/ftb_unit_chk.sv ----
// assertion checker for the flag test and branch unit
`timescale 1ns/1ps
`default_nettype none
module ftb_unit_chk (
    input wire logic        mclk,     // core clock
    input wire logic        resetn,   // async reset, active low
    input wire logic        issue,    // instruction presented
    input wire logic [31:0] instr,    // instruction word
    input wire logic        busy,     // in progress
    input wire logic        done,     // last cycle pulse
    input wire logic        claimed,  // accept pulse
    input wire logic        flags_we, // flags pulse
    input wire logic        wb_we,    // write pulse
    input wire logic        jump      // taken pulse
);
    logic [3:0] cnt_q;
    logic       br_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // cycles since claim; branch kind caught when an idle unit sees a valid word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
            br_q  <= 1'b0;
        end else begin
            cnt_q <= claimed ? 4'h1 : (busy ? cnt_q + 4'h1 : cnt_q);
            if (issue && !busy && (instr[31:27] == 5'h0C || instr[31:27] == 5'h1D)) begin
                br_q <= instr[31];
            end
        end
    end
    // ========================================
    // timing and pulse relations
    a_alu_four:   assert property (done && !br_q |-> cnt_q == 4'h3)
        else $error("and op length wrong");
    a_taken_four: assert property (done && jump |-> cnt_q == 4'h3)
        else $error("taken branch length wrong");
    a_fall_eight: assert property (done && br_q && !jump |-> cnt_q == 4'h7)
        else $error("fall through length wrong");
    a_jump_branch: assert property (jump |-> br_q && done)
        else $error("jump outside a branch");
    a_flags_done: assert property (flags_we |-> done)
        else $error("flags pulse without done");
    a_wb_done:    assert property (wb_we |-> done)
        else $error("write pulse without done");
    a_done_pulse: assert property (done |-> !busy && flags_we ##1 !done)
        else $error("done not a single idle pulse");
    a_claim_busy: assert property (claimed |-> busy ##1 !claimed)
        else $error("claim without busy");
endmodule
bind ftb_unit ftb_unit_chk u_chk (.mclk(mclk), .resetn(resetn), .issue(issue),
    .instr(instr), .busy(busy), .done(done), .claimed(claimed),
    .flags_we(flags_we), .wb_we(wb_we), .jump(jump));
`default_nettype wire

// ---- verif/ftb_rf_model.sv ----
// register file model that feeds operands and takes write-back
`timescale 1ns/1ps
`default_nettype none
module ftb_rf_model (
    input  wire logic        mclk,    // core clock
    input  wire logic [31:0] instr,   // instruction word
    input  wire logic        wb_we,   // write pulse
    input  wire logic [8:0]  wb_addr, // write index
    input  wire logic [31:0] wb_data, // write data
    output logic      [31:0] dst_val, // destination value
    output logic      [31:0] src_val  // source value
);
    logic [31:0] mem [0:511];
    // operands follow the index fields with no delay
    assign dst_val = mem[instr[17:9]];
    assign src_val = mem[instr[8:0]];
    // write-back lands at the edge after the pulse is seen
    always @(posedge mclk) begin
        if (wb_we === 1'b1) begin
            mem[wb_addr] <= wb_data;
        end
    end
endmodule
`default_nettype wire

// ---- verif/ftb_unit_tb_top.sv ----
// self-checking testbench for the flag test and branch unit
`timescale 1ns/1ps
`default_nettype none
module ftb_unit_tb_top;
    import ftb_pkg::*;
    localparam logic [5:0] op_andinv = 6'h19; // and with inverted source
    logic        mclk     = 1'b0;
    logic        resetn   = 1'b0;
    logic        issue    = 1'b0;
    logic [31:0] instr    = 32'h0;
    logic        zero_in  = 1'b0;
    logic        carry_in = 1'b0;
    logic [31:0] dst_val, src_val, wb_data;
    logic [8:0]  wb_addr, jump_addr;
    logic        busy, done, claimed, zero_flag, carry_flag, flags_we, wb_we, jump;
    int          fails    = 0;
    int          compares = 0;
    ftb_unit dut (.mclk, .resetn, .issue, .instr, .dst_val, .src_val, .zero_in,
        .carry_in, .busy, .done, .claimed, .zero_flag, .carry_flag, .flags_we,
        .wb_we, .wb_addr, .wb_data, .jump, .jump_addr);
    ftb_rf_model rf (.mclk, .instr, .wb_we, .wb_addr, .wb_data, .dst_val, .src_val);
    always #4 mclk = ~mclk;
    // ========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // eff is {zero update, carry update, write, literal}; literal uses s[8:0]
    task automatic run(input logic [5:0] op, input logic [3:0] eff,
                       input logic [31:0] d, input logic [31:0] s, input logic zi);
        logic [31:0] sv, r, wd;
        logic        br, ez, ec, ej;
        int          n;
        sv = eff[0] ? {23'h0, s[8:0]} : s;
        br = op[5];
        r  = (op == op_andinv) ? (d & ~sv) : (d & sv);
        ez = eff[3] ? (br ? (d == 32'h0) : (r == 32'h0)) : zi;
        ec = eff[2] ? (br ? 1'b0 : ^r) : zi;
        ej = br && ((op == FTB_OP_BRZ) == (d == 32'h0));
        wd = br ? d : r;
        // a spare edge lets the last write-back land in the model first
        repeat (2) @(posedge mclk);
        rf.mem[9'h010] <= d;
        rf.mem[9'h020] <= s;
        instr    <= {op, eff, 4'h0, 9'h010, eff[0] ? s[8:0] : 9'h020};
        zero_in  <= zi;
        carry_in <= zi;
        issue    <= 1'b1;
        @(posedge mclk);
        issue <= 1'b0;
        #1;
        n = 0;
        // bounded wait: a hung unit shows as a missing done
        while (done !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(done, 32'h1);
        chk(n + 1, (br && !ej) ? FTB_CYC_FALL : FTB_CYC_ALU);
        chk(flags_we, 32'h1);
        chk(zero_flag, ez);
        chk(carry_flag, ec);
        chk(wb_we, eff[1]);
        chk(jump, ej);
        if (eff[1]) begin
            chk(wb_data, wd);
            chk(wb_addr, 32'h10);
        end
        if (ej) begin
            chk(jump_addr, sv[8:0]);
        end
    endtask
    // ========================================
    // scenarios
    task automatic sc_and();
        run(FTB_OP_TEST, 4'hE, 32'hA, 32'h5, 1'b0);
        run(FTB_OP_TEST, 4'hC, 32'hA, 32'h7, 1'b1);
        run(FTB_OP_TEST, 4'hE, 32'hA, 32'hF, 1'b1);
        run(FTB_OP_TEST, 4'h0, 32'hA, 32'h5, 1'b0);
        run(FTB_OP_TEST, 4'h0, 32'hA, 32'h7, 1'b0);
        run(FTB_OP_TEST, 4'hF, 32'hFFFFFFFF, 32'hFFFFF1FF, 1'b0);
    endtask
    task automatic sc_and_inv();
        run(op_andinv, 4'hE, 32'hF731125A, 32'hFFFFFFFA, 1'b0);
        run(op_andinv, 4'hC, 32'hF731125A, 32'hFFFFFFF8, 1'b0);
        run(op_andinv, 4'hE, 32'hF731125A, 32'hFFFFFFF0, 1'b1);
        run(op_andinv, 4'hF, 32'hFFFFFFFF, 32'h000001FF, 1'b0);
    endtask
    task automatic sc_branch();
        run(FTB_OP_BRNZ, 4'hC, 32'h1, 32'h0000F123, 1'b1);
        run(FTB_OP_BRNZ, 4'hD, 32'h0, 32'h5A, 1'b0);
        run(FTB_OP_BRZ, 4'hD, 32'h0, 32'h1A5, 1'b0);
        run(FTB_OP_BRZ, 4'hE, 32'h80000000, 32'h77, 1'b1);
    endtask
    // a word of no known field is ignored, so the unit stays idle
    task automatic sc_refuse();
        @(posedge mclk);
        instr <= 32'h0;
        issue <= 1'b1;
        @(posedge mclk);
        issue <= 1'b0;
        repeat (3) begin
            @(posedge mclk);
            #1;
            chk(claimed | busy, 32'h0);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // reset, then every scenario in turn
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        sc_and();
        sc_refuse();
        sc_and_inv();
        sc_branch();
        stop_test();
    end
    // 14 runs of at most 10 cycles each; about eighteen times that before giving up
    initial begin
        #20000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
